// file: crf_device.sv
// device end: interrupt bytes, time slot table, base registers, common command word
// Notes on behaviour
// [RQ1] pending bits set by events, cleared on reaction
// [RQ2] event order power parity protect break stop disc opcode cp
// [RQ3] software writes enable; reaction clears enable bits
// [RQ4] taken byte set by hardware, cleared by software
// [RQ5] select slot owner base register for address
// [RQ6] software loads each processor base register
// [RQ7] schedule entry: assign flag plus processor number
// [RQ8] slot counter walks 0..15 and wraps
// [RQ9] adjacent run: only first and alternate slots granted
// [RQ10] slot 0 owner from switch unless test mode
// [RQ11] override byte invalidates owning processor slots
// [RQ12] maintenance fields alter slot usage
// [RQ13] command word presented to all units
// [RQ14] software sets transfer flag after placing command
// [RQ15] recipient clears transfer flag
// [RQ16] recipient reports completion via complete bit; for deferred opcodes the partner only clears the flag
// [RQ17] interrupt only when pending and enabled
// [RQ18] reaction clears enables of equal/lower priority; for any event below parity the code clears all of bits 5..0
// [RQ19] processor traps to location 10 hex
// [RQ20] programmed bit i interrupts processor i, auto-cleared
// [RQ21] event in clear cycle stays pending
// [RQ22] slot choice registered one slot ahead
//
// Design decision made here: the plain strobed port.
module crf_device
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [crf_pkg::CRF_ADDR_W-1:0] ADDR,
    input wire logic [crf_pkg::CRF_DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [crf_pkg::CRF_DATA_W-1:0] RDATA,
    input wire logic [2:0] PROCESSOR_SELECT_SWITCH,
    input wire logic TEST_MODE,
    crf_link_if.device LINK
);
    import crf_pkg::*;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] slot_override_control;
    logic [7:0] programmed_interrupt_control;
    logic [7:0] pending_events;
    logic [7:0] event_enable;
    logic [7:0] taken_interrupts;
    logic [31:0] slot_schedule_low;
    logic [31:0] slot_schedule_high;
    logic [CRF_CMD_W-1:0] common_command_word;
    logic command_transfer_flag;
    logic command_complete_seen;
    logic [CRF_BASE_W-1:0] base_reg [CRF_VP_COUNT];
    logic [2:0] base_sel;
    // maintenance: [0] burst hold, [1] force processor, [4:2] processor
    logic [4:0] maint_ctrl;
    logic [3:0] slot_count;
    logic [7:0] event_s1;
    logic [7:0] event_s2;
    logic test_s1;
    logic test_s2;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic [2:0] slot_vp;
    logic slot_valid;
    logic [2:0] prev_vp;
    logic prev_valid;
    logic prev_granted;
    logic auto_int_req;
    logic [7:0] prog_int_req;
    logic [CRF_BASE_W-1:0] slot_base;

    wire logic wr_hit_pend = WR && (ADDR == CRF_OFS_PENDING);
    wire logic react = LINK.auto_int_ack;
    wire logic [7:0] firing = pending_events & event_enable;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        event_s1 <= LINK.event_in;
        event_s2 <= event_s1;
        test_s1 <= TEST_MODE;
        test_s2 <= test_s1;
        sel_s1 <= PROCESSOR_SELECT_SWITCH;
        sel_s2 <= sel_s1;
    end

    // ----------------------------------------------------------------
    // automatic interrupt bytes
    // ----------------------------------------------------------------
    // power fail is bit 7, stop button bit 3, cp interrupt bit 0 [RQ2]
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            pending_events <= CRF_RESET_BYTE;
        else
        begin
            // software may only erase; a fresh event outranks any clear [RQ1] [RQ21]
            pending_events <= ((wr_hit_pend ? (pending_events & WDATA[7:0]) : pending_events)
                & ~(react ? firing : 8'h00)) | event_s2;
        end
    end

    function automatic logic [7:0] lower_mask(input logic [7:0] f);
        if (f[CRF_EV_POWER_FAIL])
            return 8'hFF;
        else if (f[CRF_EV_MEM_PARITY])
            return 8'h7F;
        else if (f != 8'h00)
            return 8'h3F;
        else
            return 8'h00;
    endfunction : lower_mask

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            event_enable <= CRF_RESET_BYTE;
        else if (react)
            event_enable <= event_enable & ~lower_mask(firing); // [RQ3] [RQ18]
        else if (WR && ADDR == CRF_OFS_ENABLE)
            event_enable <= WDATA[7:0]; // [RQ3]
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            taken_interrupts <= CRF_RESET_BYTE;
        else
            // hardware set wins over the software clear [RQ4]
            taken_interrupts <= ((WR && ADDR == CRF_OFS_TAKEN) ? (taken_interrupts & WDATA[7:0])
                : taken_interrupts) | (react ? firing : 8'h00);
    end

    // the trap address CRF_TRAP_AUTO is applied by the processor on ack [RQ19]
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            auto_int_req <= 1'b0;
        else
            auto_int_req <= (firing & ~(react ? firing : 8'h00)) != 8'h00; // [RQ17]
    end

    // ----------------------------------------------------------------
    // programmed interrupts
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            programmed_interrupt_control <= CRF_RESET_BYTE;
        else if (WR && ADDR == CRF_OFS_PROG_INT)
            programmed_interrupt_control <= WDATA[7:0] & ~LINK.prog_int_ack;
        else
            programmed_interrupt_control <= programmed_interrupt_control & ~LINK.prog_int_ack; // [RQ20]
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            prog_int_req <= 8'h00;
        else
            prog_int_req <= programmed_interrupt_control & ~LINK.prog_int_ack; // [RQ20]
    end

    // ----------------------------------------------------------------
    // schedule table, override, base registers, maintenance
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            slot_override_control <= CRF_RESET_BYTE;
            slot_schedule_low <= CRF_RESET_WORD;
            slot_schedule_high <= CRF_RESET_WORD;
            maint_ctrl <= 5'h00;
            base_sel <= 3'h0;
        end
        else if (WR)
        begin
            case (ADDR)
                CRF_OFS_OVERRIDE: slot_override_control <= WDATA[7:0];
                CRF_OFS_SCHED_LOW: slot_schedule_low <= WDATA;
                CRF_OFS_SCHED_HIGH: slot_schedule_high <= WDATA;
                CRF_OFS_MAINT: maint_ctrl <= WDATA[4:0];
                CRF_OFS_BASE_SEL: base_sel <= WDATA[2:0];
                default: ;
            endcase
        end
    end

    // base registers are loaded by software through a select register [RQ6]
    always_ff @(posedge REF_CLK)
    begin
        if (WR && ADDR == CRF_OFS_BASE0)
            base_reg[base_sel] <= WDATA[CRF_BASE_W-1:0];
    end

    // entry n: 4-bit nibble, flag at msb; slot order 0,8,1,9.. in low word, 4,12,5,13.. in high word [RQ7]
    function automatic logic [3:0] slot_assign_entry(input logic [3:0] s, input logic [31:0] lo,
        input logic [31:0] hi);
        logic [31:0] w;
        logic [2:0] pos;
        w = s[2] ? hi : lo;
        pos = {s[1:0], s[3]};
        return w[31 - 4*pos -: 4];
    endfunction : slot_assign_entry

    // ----------------------------------------------------------------
    // slot sequencing, one slot ahead
    // ----------------------------------------------------------------
    logic [3:0] next_slot;
    logic [3:0] next_entry;
    logic [2:0] next_vp;
    logic next_valid;
    always_comb
    begin
        next_slot = slot_count + 4'h1; // wraps 15 to 0 [RQ8]
        next_entry = slot_assign_entry(next_slot, slot_schedule_low, slot_schedule_high); // [RQ8]
        next_vp = next_entry[2:0];
        next_valid = next_entry[3]; // [RQ7]
        if (next_slot == 4'h0 && !test_s2)
        begin
            next_vp = sel_s2; // [RQ10]
            next_valid = 1'b1;
        end
        if (slot_override_control[3'h7 - next_vp])
            next_valid = 1'b0; // [RQ11]
        if (next_valid && prev_valid && prev_vp == next_vp && prev_granted)
            next_valid = 1'b0; // [RQ9]
        if (maint_ctrl[1])
            next_valid = next_valid && next_vp == maint_ctrl[4:2]; // [RQ12]
        if (maint_ctrl[0])
            next_valid = 1'b0; // [RQ12]
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            slot_count <= 4'hF;
            slot_vp <= 3'h0;
            slot_valid <= 1'b0;
            prev_vp <= 3'h0;
            prev_valid <= 1'b0;
            prev_granted <= 1'b0;
            slot_base <= '0;
        end
        else
        begin
            slot_count <= next_slot; // [RQ8]
            slot_vp <= next_vp; // [RQ22]
            slot_valid <= next_valid; // [RQ22]
            slot_base <= base_reg[next_vp]; // [RQ5]
            prev_vp <= next_vp;
            prev_valid <= next_entry[3] || (next_slot == 4'h0 && !test_s2);
            prev_granted <= next_valid;
        end
    end

    // ----------------------------------------------------------------
    // common command word and transfer flag
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            common_command_word <= 16'h0000;
            command_transfer_flag <= 1'b0;
        end
        else if (WR && ADDR == CRF_OFS_COMMAND)
        begin
            common_command_word <= WDATA[CRF_CMD_W-1:0]; // [RQ13]
            command_transfer_flag <= WDATA[CRF_CMD_FLAG_BIT]; // [RQ14]
        end
        else if (LINK.command_flag_clear)
            command_transfer_flag <= 1'b0; // [RQ15]
    end

    // recipient completion kept sticky for software, cleared by a command write [RQ16]
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            command_complete_seen <= 1'b0;
        else if (LINK.command_complete)
            command_complete_seen <= 1'b1;
        else if (WR && ADDR == CRF_OFS_COMMAND)
            command_complete_seen <= 1'b0;
    end

    // ----------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            RDATA <= CRF_RESET_WORD;
        else if (RD)
        begin
            case (ADDR)
                CRF_OFS_OVERRIDE: RDATA <= {24'h000000, slot_override_control};
                CRF_OFS_PROG_INT: RDATA <= {24'h000000, programmed_interrupt_control};
                CRF_OFS_PENDING: RDATA <= {24'h000000, pending_events};
                CRF_OFS_ENABLE: RDATA <= {24'h000000, event_enable};
                CRF_OFS_TAKEN: RDATA <= {24'h000000, taken_interrupts};
                CRF_OFS_VP_STATUS: RDATA <= {24'h000000, slot_valid, slot_vp, slot_count};
                CRF_OFS_SCHED_LOW: RDATA <= slot_schedule_low;
                CRF_OFS_SCHED_HIGH: RDATA <= slot_schedule_high;
                CRF_OFS_MAINT: RDATA <= {27'h0000000, maint_ctrl};
                CRF_OFS_COMMAND: RDATA <= {14'h0000, command_complete_seen, command_transfer_flag,
                    common_command_word};
                CRF_OFS_BASE0: RDATA <= {16'h0000, base_reg[base_sel]};
                CRF_OFS_BASE_SEL: RDATA <= {29'h00000000, base_sel};
                default: RDATA <= CRF_RESET_WORD;
            endcase
        end
    end

    assign LINK.slot_vp = slot_vp;
    assign LINK.slot_valid = slot_valid;
    assign LINK.slot_base = slot_base;
    assign LINK.auto_int_req = auto_int_req;
    assign LINK.prog_int_req = prog_int_req;
    assign LINK.command_word = common_command_word; // [RQ13]
    assign LINK.command_transfer_flag = command_transfer_flag;
endmodule : crf_device

// file: crf_link_asserts.sv
// checker: concurrent assertions on the link between the two ends
module crf_link_asserts
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic auto_int_req,
    input wire logic auto_int_ack,
    input wire logic [7:0] prog_int_req,
    input wire logic [7:0] prog_int_ack,
    input wire logic [crf_pkg::CRF_CMD_W-1:0] command_word,
    input wire logic command_transfer_flag,
    input wire logic command_flag_clear,
    input wire logic command_complete
);
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // ----------------------------------------
    // interrupt handshakes
    // ----------------------------------------
    a_auto_ack_req: assert property (auto_int_ack |-> auto_int_req)
        else $error("auto ack without a request");
    a_auto_ack_drops: assert property (auto_int_ack |-> ##2 !auto_int_req)
        else $error("auto request stays after ack");
    a_prog_ack_req: assert property ((prog_int_ack & ~prog_int_req) == 8'h00)
        else $error("programmed ack without a request");
    a_prog_req_clears: assert property ((prog_int_ack != 8'h00) |-> ##2
        ((prog_int_req & $past(prog_int_ack, 2)) == 8'h00))
        else $error("programmed request not cleared by ack");
    // ----------------------------------------
    // command word handshake
    // ----------------------------------------
    a_clear_needs_flag: assert property (command_flag_clear |-> command_transfer_flag)
        else $error("flag clear while no command pending");
    a_flag_clear_drops: assert property (command_flag_clear |-> ##[1:2] !command_transfer_flag)
        else $error("transfer flag not dropped after clear");
    a_word_held: assert property ((command_transfer_flag && $past(command_transfer_flag))
        |-> $stable(command_word))
        else $error("command word moved while pending");
    a_complete_after_clear: assert property (command_complete |-> !command_transfer_flag)
        else $error("completion while flag still set");
endmodule : crf_link_asserts

// file: crf_link_if.sv
// interface: register file toward virtual processors and command recipients
interface crf_link_if;
    import crf_pkg::*;
    logic [2:0] slot_vp;
    logic slot_valid;
    logic [CRF_BASE_W-1:0] slot_base;
    logic auto_int_req;
    logic [7:0] prog_int_req;
    logic auto_int_ack;
    logic [7:0] prog_int_ack;
    logic [7:0] event_in;
    logic [CRF_CMD_W-1:0] command_word;
    logic command_transfer_flag;
    logic command_flag_clear;
    logic command_complete;
    modport device (output slot_vp, slot_valid, slot_base, auto_int_req, prog_int_req, command_word,
        command_transfer_flag, input auto_int_ack, prog_int_ack, event_in, command_flag_clear, command_complete);
    modport partner (input slot_vp, slot_valid, slot_base, auto_int_req, prog_int_req, command_word,
        command_transfer_flag, output auto_int_ack, prog_int_ack, event_in, command_flag_clear, command_complete);
endinterface : crf_link_if

// file: crf_partner.sv
// partner end: virtual processor interrupt acks and a command recipient unit
module crf_partner
#(
    parameter logic [3:0] UNIT_ID = 4'h1,
    parameter logic [3:0] DEFERRED_OPS_FROM = 4'h8
)
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [7:0] EVENTS,
    input wire logic AUTO_TAKE,
    input wire logic [7:0] PROG_TAKE,
    input wire logic CMD_DONE,
    output logic [crf_pkg::CRF_CMD_W-1:0] CMD_SEEN,
    output logic CMD_BUSY,
    output logic [15:0] TRAP_ADDR,
    crf_link_if.partner LINK
);
    import crf_pkg::*;

    // ----------------------------------------------------------------
    // interrupt response
    // ----------------------------------------------------------------
    logic auto_ack;
    logic [7:0] prog_ack;
    logic [7:0] event_pulse;
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            auto_ack <= 1'b0;
            prog_ack <= 8'h00;
            event_pulse <= 8'h00;
            TRAP_ADDR <= 16'h0000;
        end
        else
        begin
            auto_ack <= AUTO_TAKE && LINK.auto_int_req && !auto_ack; // [RQ19]
            prog_ack <= PROG_TAKE & LINK.prog_int_req & ~prog_ack; // [RQ20]
            event_pulse <= EVENTS;
            if (AUTO_TAKE && LINK.auto_int_req && !auto_ack)
                TRAP_ADDR <= CRF_TRAP_AUTO; // [RQ19]
        end
    end

    // ----------------------------------------------------------------
    // command recipient
    // ----------------------------------------------------------------
    crf_cmd_state_type state;
    logic flag_clear;
    logic complete;
    wire logic addressed = LINK.command_transfer_flag && LINK.command_word[15:12] == UNIT_ID;
    wire logic deferred = LINK.command_word[11:8] >= DEFERRED_OPS_FROM;
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            state <= CRF_CMD_IDLE;
            flag_clear <= 1'b0;
            complete <= 1'b0;
            CMD_SEEN <= 16'h0000;
            CMD_BUSY <= 1'b0;
        end
        else
        begin
            flag_clear <= 1'b0;
            complete <= 1'b0;
            case (state)
                CRF_CMD_IDLE:
                    if (addressed && !flag_clear)
                    begin
                        CMD_SEEN <= LINK.command_word;
                        CMD_BUSY <= 1'b1;
                        flag_clear <= !deferred; // clear on receipt [RQ15]
                        state <= deferred ? CRF_CMD_DONE : CRF_CMD_TAKEN;
                    end
                CRF_CMD_TAKEN:
                    if (CMD_DONE)
                    begin
                        complete <= 1'b1; // [RQ16]
                        CMD_BUSY <= 1'b0;
                        state <= CRF_CMD_IDLE;
                    end
                CRF_CMD_DONE:
                    if (CMD_DONE)
                    begin
                        flag_clear <= 1'b1; // clear on finish [RQ15]
                        CMD_BUSY <= 1'b0;
                        state <= CRF_CMD_IDLE;
                    end
                default: state <= CRF_CMD_IDLE;
            endcase
        end
    end

    assign LINK.auto_int_ack = auto_ack;
    assign LINK.prog_int_ack = prog_ack;
    assign LINK.event_in = event_pulse;
    assign LINK.command_flag_clear = flag_clear;
    assign LINK.command_complete = complete;
endmodule : crf_partner

// file: crf_pkg.sv
// package: constants and types for the comm register file slice
package crf_pkg;
    localparam int CRF_VP_COUNT = 8;
    localparam int CRF_SLOT_COUNT = 16;
    localparam int CRF_ADDR_W = 4;
    localparam int CRF_DATA_W = 32;
    // word offsets of the register file
    localparam logic [3:0] CRF_OFS_OVERRIDE = 4'h0;
    localparam logic [3:0] CRF_OFS_PROG_INT = 4'h2;
    localparam logic [3:0] CRF_OFS_PENDING = 4'h3;
    localparam logic [3:0] CRF_OFS_ENABLE = 4'h4;
    localparam logic [3:0] CRF_OFS_TAKEN = 4'h5;
    localparam logic [3:0] CRF_OFS_VP_STATUS = 4'h6;
    localparam logic [3:0] CRF_OFS_SCHED_LOW = 4'h8;
    localparam logic [3:0] CRF_OFS_SCHED_HIGH = 4'h9;
    localparam logic [3:0] CRF_OFS_MAINT = 4'hA;
    localparam logic [3:0] CRF_OFS_COMMAND = 4'hC;
    localparam logic [3:0] CRF_OFS_BASE0 = 4'hD;
    localparam logic [3:0] CRF_OFS_BASE_SEL = 4'hE;
    // event bit positions (bit 7 is the first listed event)
    localparam int CRF_EV_POWER_FAIL = 7;
    localparam int CRF_EV_MEM_PARITY = 6;
    // command word layout: target[15:12] opcode[11:8] address[7:0], flag at bit 16
    localparam int CRF_CMD_W = 16;
    localparam int CRF_CMD_FLAG_BIT = 16;
    localparam logic [7:0] CRF_RESET_BYTE = 8'h00;
    localparam logic [31:0] CRF_RESET_WORD = 32'h00000000;
    localparam logic [15:0] CRF_TRAP_AUTO = 16'h0010;
    localparam int CRF_BASE_W = 16;
    typedef enum logic [1:0] {CRF_CMD_IDLE = 2'b00, CRF_CMD_TAKEN = 2'b01, CRF_CMD_DONE = 2'b10} crf_cmd_state_type;
endpackage : crf_pkg

// file: testbench.sv
// testbench: register port tests with both link ends facing each other
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;
    logic ref_clk, rst_b, wr, rd, test_mode, auto_take, cmd_done, cmd_busy;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v, prev;
    logic [2:0] sw, ev_vp;
    logic [7:0] events, prog_take, ovr;
    logic [15:0] cmd_seen, trap_addr;
    logic [3:0] ofs [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'h7};
    logic [7:0] ev_tab [3] = '{8'h10, 8'h40, 8'h80};
    logic [7:0] en_tab [3] = '{8'hC0, 8'h80, 8'h00};
    int err_count = 0;
    int compares = 0;
    int n_valid;
    int exp_valid [4] = '{5, 4, 0, 1};
    logic [31:0] maint_tab [4] = '{32'h00000000, 32'h00000000, 32'h00000001, 32'h00000016};
    crf_link_if link ();
    crf_device i_crf_device (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PROCESSOR_SELECT_SWITCH(sw), .TEST_MODE(test_mode), .LINK(link));
    crf_partner #(.UNIT_ID(4'h1), .DEFERRED_OPS_FROM(4'h8)) i_crf_partner (.REF_CLK(ref_clk), .RST_B(rst_b),
        .EVENTS(events), .AUTO_TAKE(auto_take), .PROG_TAKE(prog_take), .CMD_DONE(cmd_done), .CMD_SEEN(cmd_seen),
        .CMD_BUSY(cmd_busy), .TRAP_ADDR(trap_addr), .LINK(link));
    crf_link_asserts i_crf_link_asserts (.REF_CLK(ref_clk), .RST_B(rst_b), .auto_int_req(link.auto_int_req),
        .auto_int_ack(link.auto_int_ack), .prog_int_req(link.prog_int_req), .prog_int_ack(link.prog_int_ack),
        .command_word(link.command_word), .command_transfer_flag(link.command_transfer_flag),
        .command_flag_clear(link.command_flag_clear), .command_complete(link.command_complete));
    // ----------------------------------------
    // clock and run limit
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // whole sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        summarize();
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data appear in the cycle after the strobe and hold until the next read
    // called on a clock edge, so the strobe rises there and the data are taken two edges later
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        d = rdata;
    endtask : rd_reg
    task automatic pulse_done();
        cmd_done <= 1'b1;
        @(posedge ref_clk);
        cmd_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : pulse_done
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        {rst_b, wr, rd, test_mode, auto_take, cmd_done, addr, wdata, events, prog_take} = '0;
        sw = 3'd5;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        wr_reg(4'h7, 32'hFFFFFFFF);
        foreach (ofs[i])
        begin
            rd_reg(ofs[i], v);
            check(v, 32'h00000000);
        end
        wr_reg(CRF_OFS_SCHED_LOW, 32'h8C9DAEBF);
        wr_reg(CRF_OFS_SCHED_HIGH, 32'h8C9DAEBF);
        rd_reg(CRF_OFS_SCHED_HIGH, v);
        check(v, 32'h8C9DAEBF);
        $display("test registers done");
        for (int p = 0; p < 2; p++)
        begin
            ovr = (p == 1) ? 8'h03 : 8'h00;
            wr_reg(CRF_OFS_OVERRIDE, {24'h0, ovr});
            rd_reg(CRF_OFS_VP_STATUS, prev);
            repeat (8)
            begin
                rd_reg(CRF_OFS_VP_STATUS, v);
                check(v[3:0], 4'(prev[3:0] + 4'h2));
                ev_vp = (v[3:0] == 4'h0) ? sw : {v[3], v[1:0]};
                check(v[7:4], {(v[3:0] == 4'h0) || !ovr[3'd7 - ev_vp], ev_vp});
                prev = v;
            end
        end
        $display("test slots done");
        wr_reg(CRF_OFS_SCHED_LOW, 32'h88888888);
        wr_reg(CRF_OFS_SCHED_HIGH, 32'h00000000);
        wr_reg(CRF_OFS_BASE_SEL, 32'h00000005);
        wr_reg(CRF_OFS_BASE0, 32'h00005A5A);
        rd_reg(CRF_OFS_BASE0, v);
        check(v, 32'h00005A5A);
        // normal, test mode, maintenance hold, maintenance force to processor 5
        for (int t = 0; t < 4; t++)
        begin
            test_mode <= (t == 1);
            wr_reg(CRF_OFS_MAINT, maint_tab[t]);
            repeat (20) @(posedge ref_clk);
            n_valid = 0;
            repeat (16)
            begin
                @(posedge ref_clk);
                n_valid += link.slot_valid;
                if (link.slot_vp == 3'h5)
                    check(link.slot_base, 32'h00005A5A);
            end
            check(n_valid, exp_valid[t]);
        end
        $display("test slot grants done");
        events <= 8'h01;
        repeat (2) @(posedge ref_clk);
        events <= 8'h00;
        repeat (6) @(posedge ref_clk);
        rd_reg(CRF_OFS_PENDING, v);
        check(v, 32'h00000001);
        check(link.auto_int_req, 1'b0);
        wr_reg(CRF_OFS_PENDING, 32'h00000000);
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(CRF_OFS_ENABLE, 32'h000000FF);
            events <= ev_tab[i];
            repeat (2) @(posedge ref_clk);
            // the last event is held through the reaction, so it must stay pending
            events <= (i == 2) ? ev_tab[i] : 8'h00;
            repeat (6) @(posedge ref_clk);
            rd_reg(CRF_OFS_PENDING, v);
            check(v, {24'h0, ev_tab[i]});
            check(link.auto_int_req, 1'b1);
            auto_take <= 1'b1;
            for (int n = 0; n < 50 && link.auto_int_req !== 1'b0; n++) @(posedge ref_clk);
            auto_take <= 1'b0;
            events <= 8'h00;
            check(trap_addr, 16'h0010);
            rd_reg(CRF_OFS_PENDING, v);
            check(v, (i == 2) ? {24'h0, ev_tab[i]} : 32'h00000000);
            rd_reg(CRF_OFS_TAKEN, v);
            check(v, {24'h0, ev_tab[i]});
            rd_reg(CRF_OFS_ENABLE, v);
            check(v, {24'h0, en_tab[i]});
            wr_reg(CRF_OFS_TAKEN, 32'h00000000);
            rd_reg(CRF_OFS_TAKEN, v);
            check(v, 32'h00000000);
        end
        $display("test automatic interrupts done");
        wr_reg(CRF_OFS_PROG_INT, 32'h00000024);
        repeat (2) @(posedge ref_clk);
        check(link.prog_int_req, 8'h24);
        prog_take <= 8'h04;
        for (int n = 0; n < 100 && link.prog_int_req[2] !== 1'b0; n++) @(posedge ref_clk);
        prog_take <= 8'h00;
        rd_reg(CRF_OFS_PROG_INT, v);
        check(v, 32'h00000020);
        $display("test programmed interrupts done");
        wr_reg(CRF_OFS_COMMAND, 32'h00011234);
        repeat (4) @(posedge ref_clk);
        check(link.command_word, 16'h1234);
        check(cmd_seen, 16'h1234);
        check(cmd_busy, 1'b1);
        rd_reg(CRF_OFS_COMMAND, v);
        check(v[16], 1'b0);
        pulse_done();
        rd_reg(CRF_OFS_COMMAND, v);
        check(v[17], 1'b1);
        check(cmd_busy, 1'b0);
        wr_reg(CRF_OFS_COMMAND, 32'h00011955);
        repeat (4) @(posedge ref_clk);
        rd_reg(CRF_OFS_COMMAND, v);
        check(v[16], 1'b1);
        pulse_done();
        rd_reg(CRF_OFS_COMMAND, v);
        check(v[16], 1'b0);
        wr_reg(CRF_OFS_COMMAND, 32'h00012100);
        repeat (4) @(posedge ref_clk);
        pulse_done();
        rd_reg(CRF_OFS_COMMAND, v);
        check(v[16], 1'b1);
        wr_reg(CRF_OFS_COMMAND, 32'h00000000);
        $display("test command word done");
        summarize();
    end
endmodule : testbench
